//--- hw/hub_cfg_pkg.sv
// Constants shared by the hub port disable and power configuration block
package hub_cfg_pkg;
   // ==========================================================
   // Register map
   localparam logic [7:0] BUS_OFF_MASK_ADDR = 8'h0B;
   localparam logic [7:0] SELF_POWER_ADDR = 8'h0C;
   localparam logic [7:0] BUS_OFF_MASK_RESET = 8'h00;
   localparam logic [7:0] SELF_POWER_RESET = 8'h01;
   // ==========================================================
   // Field layout of the port off mask
   localparam int PORT_LSB = 1;
   localparam int PORT_MSB = 3;
   localparam int NUM_PORTS = 3;
   localparam logic [2:0] NO_PORTS_OFF = 3'h0;
   localparam logic [1:0] NO_PORT = 2'h0;
   // ==========================================================
   // Power units
   localparam int POWER_UNIT_MA = 2;
   localparam int SELF_POWER_LIMIT_MA = 100;
endpackage

//--- hw/port_map_if.sv
// Interface carrying the port off mask and the resulting host port map
interface port_map_if;
   import hub_cfg_pkg::*;
   logic [3:1] off_mask;
   logic [1:0] port_count;
   logic [3:1][1:0] log_phys;
   modport cfg (output off_mask, input port_count, input log_phys);
   modport mapper (input off_mask, output port_count, output log_phys);
endinterface

//--- hw/port_remap.sv
// Packs the enabled physical ports into contiguous host port numbers
module port_remap
   import hub_cfg_pkg::*;
(
   // Mask in, map out
   port_map_if.mapper pm
);
   logic [2:0] slot;
   logic [3:1][1:0] next_map;

   // ==========================================================
   // Packing
   // Any mix of ports may be off; lower physical ports take lower slots
   always_comb begin // see R3
      slot = 3'h1;
      next_map = '0;
      for (int p = PORT_LSB; p <= PORT_MSB; p++) begin
         if (!pm.off_mask[p]) begin // see R5
            next_map[slot[1:0]] = 2'(p);
            slot = slot + 3'h1;
         end
      end
   end

   assign pm.log_phys = next_map;
   assign pm.port_count = 2'(slot - 3'h1); // see R4
endmodule // port_remap

//--- hw/hub_port_power_cfg.sv
// Port disable and self powered max power registers with the host port map
//
// Contract
// R1: Mask bit one disables port, zero leaves it
// R2: Bus powered, no remap: masked ports stay off
// R3: Any combination of disabled ports is accepted
// R4: Reported port count equals enabled ports
// R5: Active ports renumbered contiguously for the host
// R6: Bits 3..1 are ports 3..1, others reserved
// R7: Port off mask resets to zero
// R8: Max power count is in 2 mA units
// R9: Software includes board circuitry in max power
// R10: Software includes zero-current embedded peripheral power
// R11: Software keeps max power at or under 100 mA
// R12: Self powered max power resets to one
// R13: Remap enabled: remap registers decide port arrangement
// R14: Self powered: descriptor carries stored count unchanged
module hub_port_power_cfg
   import hub_cfg_pkg::*;
(
   // Clock and reset
   input wire logic mclk,
   input wire logic reset,
   // Configuration register port
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [7:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   output logic [7:0] reg_rdata,
   output logic reg_rd_valid,
   // Operating mode
   input wire logic bus_powered,
   input wire logic port_remap_enable,
   input wire logic [3:1] remap_off_mask,
   // Host facing port view
   output logic [3:1] port_enabled,
   output logic [1:0] reported_port_count,
   output logic [3:1][1:0] host_to_phys,
   // Descriptor power field
   output logic [7:0] desc_max_power,
   output logic desc_max_power_valid
);
   logic [7:0] bus_powered_port_off_mask;
   logic [7:0] self_powered_max_power;
   logic [3:1] bus_powered_port_off_bits;
   logic [7:0] self_powered_power_count;
   logic [3:1] next_off;
   logic [7:0] next_rdata;
   logic wr_mask;
   logic wr_power;

   port_map_if pm ();

   port_remap u_remap (
      .pm(pm)
   );

   // ==========================================================
   // Decode
   assign wr_mask = reg_wr && (reg_addr == BUS_OFF_MASK_ADDR);
   assign wr_power = reg_wr && (reg_addr == SELF_POWER_ADDR);
   assign bus_powered_port_off_bits = bus_powered_port_off_mask[PORT_MSB:PORT_LSB]; // see R6
   assign self_powered_power_count = self_powered_max_power; // see R8
   // Self powered port disable lives elsewhere, so with remap off nothing is masked here then
   assign next_off = port_remap_enable ? remap_off_mask : // see R13
                     bus_powered ? bus_powered_port_off_bits : NO_PORTS_OFF; // see R2
   assign pm.off_mask = next_off;
   assign next_rdata = (reg_addr == BUS_OFF_MASK_ADDR) ? bus_powered_port_off_mask :
                       (reg_addr == SELF_POWER_ADDR) ? self_powered_max_power : 8'h00;

   // ==========================================================
   // Registers
   // Reserved bits are not stored, so they always read back as zero
   always_ff @(posedge mclk or posedge reset) begin
      if (reset) begin
         bus_powered_port_off_mask <= BUS_OFF_MASK_RESET; // see R7
         self_powered_max_power <= SELF_POWER_RESET; // see R12
      end else begin
         if (wr_mask) begin
            bus_powered_port_off_mask <= {4'h0, reg_wdata[PORT_MSB:PORT_LSB], 1'b0}; // see R1
         end
         if (wr_power) begin
            // No clamp: keeping within the bus limit is software's job
            self_powered_max_power <= reg_wdata; // see R8
         end
      end
   end

   always_ff @(posedge mclk or posedge reset) begin
      if (reset) begin
         reg_rdata <= 8'h00;
         reg_rd_valid <= 1'b0;
      end else begin
         reg_rd_valid <= reg_rd;
         if (reg_rd) begin
            reg_rdata <= next_rdata;
         end
      end
   end

   // ==========================================================
   // Host view
   always_ff @(posedge mclk or posedge reset) begin
      if (reset) begin
         port_enabled <= '1;
         reported_port_count <= 2'h3;
         host_to_phys <= {2'h3, 2'h2, 2'h1};
         desc_max_power <= 8'h00;
         desc_max_power_valid <= 1'b0;
      end else begin
         port_enabled <= ~next_off; // see R2
         reported_port_count <= pm.port_count; // see R4
         host_to_phys <= pm.log_phys; // see R5
         desc_max_power <= bus_powered ? 8'h00 : self_powered_power_count; // see R14
         desc_max_power_valid <= !bus_powered;
      end
   end

   // ==========================================================
   // Checks
   reserved_bits_zero_a: assert property ( // see R6
      @(posedge mclk) disable iff (reset)
      bus_powered_port_off_mask[7:4] == 4'h0 && !bus_powered_port_off_mask[0])
      else $error("reserved mask bits set");

   masked_port_off_a: assert property ( // see R2
      @(posedge mclk) disable iff (reset)
      bus_powered && !port_remap_enable |=>
      port_enabled == ~$past(bus_powered_port_off_bits))
      else $error("masked port not held off");

   port_count_match_a: assert property ( // see R4
      @(posedge mclk) disable iff (reset)
      1'b1 |=> reported_port_count == 2'(NUM_PORTS - $countones($past(next_off))))
      else $error("port count mismatch");

   power_write_store_a: assert property ( // see R8
      @(posedge mclk) disable iff (reset)
      wr_power |=> self_powered_max_power == $past(reg_wdata))
      else $error("max power write lost");

   power_read_back_a: assert property ( // see R8
      @(posedge mclk) disable iff (reset)
      reg_rd && reg_addr == SELF_POWER_ADDR |=>
      reg_rd_valid && reg_rdata == $past(self_powered_max_power))
      else $error("max power read back wrong");

   mask_write_store_a: assert property ( // see R1
      @(posedge mclk) disable iff (reset)
      wr_mask |=> bus_powered_port_off_bits == $past(reg_wdata[PORT_MSB:PORT_LSB]))
      else $error("port off mask write lost");

   mask_read_back_a: assert property ( // see R6
      @(posedge mclk) disable iff (reset)
      reg_rd && reg_addr == BUS_OFF_MASK_ADDR |=>
      reg_rd_valid && reg_rdata == $past(bus_powered_port_off_mask))
      else $error("port off mask read back wrong");

   mask_hold_a: assert property ( // see R2
      @(posedge mclk) disable iff (reset)
      !wr_mask |=> $stable(bus_powered_port_off_mask))
      else $error("port off mask changed without write");

   power_hold_a: assert property ( // see R8
      @(posedge mclk) disable iff (reset)
      !wr_power |=> $stable(self_powered_max_power))
      else $error("max power changed without write");

   desc_power_copy_a: assert property ( // see R14
      @(posedge mclk) disable iff (reset)
      !bus_powered |=> desc_max_power_valid && desc_max_power == $past(self_powered_max_power))
      else $error("descriptor power wrong");

   remap_select_a: assert property ( // see R13
      @(posedge mclk) disable iff (reset)
      port_remap_enable |=> port_enabled == ~$past(remap_off_mask))
      else $error("remap mask not used");

   first_slot_used_a: assert property ( // see R5
      @(posedge mclk) disable iff (reset)
      reported_port_count != 2'h0 |->
      host_to_phys[1] != NO_PORT && port_enabled[host_to_phys[1]])
      else $error("host port one not mapped to live port");

   reset_values_a: assert property ( // see R7
      @(posedge mclk)
      $fell(reset) |-> bus_powered_port_off_mask == BUS_OFF_MASK_RESET
      && self_powered_max_power == SELF_POWER_RESET) // see R12
      else $error("bad reset values");

   // ==========================================================
   // Host view shape
   // Empty host slots read zero, so the host never sees a dead port
   self_powered_open_a: assert property ( // see R2
      @(posedge mclk) disable iff (reset)
      !bus_powered && !port_remap_enable |=> port_enabled == 3'h7)
      else $error("port off while self powered");

   desc_bus_zero_a: assert property ( // see R14
      @(posedge mclk) disable iff (reset)
      bus_powered |=> !desc_max_power_valid && desc_max_power == 8'h00)
      else $error("descriptor power shown while bus powered");

   remap_count_a: assert property ( // see R13
      @(posedge mclk) disable iff (reset)
      port_remap_enable |=>
      reported_port_count == 2'(NUM_PORTS - $countones($past(remap_off_mask))))
      else $error("remap port count wrong");

   unused_slots_zero_a: assert property ( // see R5
      @(posedge mclk) disable iff (reset)
      reported_port_count != 2'h3 |-> host_to_phys[3] == NO_PORT
      && (reported_port_count > 2'h1 || host_to_phys[2] == NO_PORT))
      else $error("unused host slot not empty");

   live_slots_order_a: assert property ( // see R5
      @(posedge mclk) disable iff (reset)
      reported_port_count > 2'h1 |->
      host_to_phys[2] > host_to_phys[1] && port_enabled[host_to_phys[2]])
      else $error("host port two out of order");

   full_map_order_a: assert property ( // see R5
      @(posedge mclk) disable iff (reset)
      reported_port_count == 2'h3 |-> host_to_phys == {2'h3, 2'h2, 2'h1})
      else $error("full map not in order");
endmodule // hub_port_power_cfg

//--- dv/cfg_master.sv
// Configuration master model driving the register port
module cfg_master (
   // Clock
   input wire logic mclk,
   // Register port
   output logic reg_wr,
   output logic reg_rd,
   output logic [7:0] reg_addr,
   output logic [7:0] reg_wdata,
   input wire logic [7:0] reg_rdata,
   input wire logic reg_rd_valid
);
   timeunit 1ns;
   timeprecision 100ps;
   initial begin
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      reg_addr = 8'h00;
      reg_wdata = 8'h00;
   end
   // Callers keep the power count at or under 0x32
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge mclk);
      #1;
      reg_addr = a;
      reg_wdata = d;
      reg_wr = 1'b1;
      @(posedge mclk);
      #1;
      reg_wr = 1'b0;
      reg_wdata = ~d;
   endtask
   // Missing valid turns the data unknown so a compare fails
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(posedge mclk);
      #1;
      reg_addr = a;
      reg_rd = 1'b1;
      @(posedge mclk);
      #1;
      reg_rd = 1'b0;
      d = (reg_rd_valid === 1'b1) ? reg_rdata : 8'hXX;
   endtask
endmodule // cfg_master

//--- dv/testbench.sv
// Self-checking bench for the port disable and power registers
module testbench
   import hub_cfg_pkg::*;
;
   timeunit 1ns;
   timeprecision 100ps;
   logic mclk, reset, reg_wr, reg_rd, reg_rd_valid, desc_max_power_valid;
   logic bus_powered, port_remap_enable;
   logic [7:0] reg_addr, reg_wdata, reg_rdata, desc_max_power, v;
   logic [3:1] remap_off_mask, port_enabled;
   logic [1:0] reported_port_count;
   logic [3:1][1:0] host_to_phys;
   int n_fail = 0;
   int checks_done = 0;
   hub_port_power_cfg uut (.mclk(mclk), .reset(reset), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
      .reg_rd_valid(reg_rd_valid), .bus_powered(bus_powered),
      .port_remap_enable(port_remap_enable), .remap_off_mask(remap_off_mask),
      .port_enabled(port_enabled), .reported_port_count(reported_port_count),
      .host_to_phys(host_to_phys), .desc_max_power(desc_max_power),
      .desc_max_power_valid(desc_max_power_valid));
   cfg_master host (.mclk(mclk), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_rd_valid(reg_rd_valid));
   // ==========================================================
   // Checking helpers
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      checks_done++;
      if (got !== exp) begin
         n_fail++;
         $display("[ERR] %0t got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic test_done();
      if (n_fail == 0 && checks_done > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask
   // Expected view for one off mask: survivors fill host slots upward
   task automatic chk_view(input logic [3:1] off);
      logic [3:1][1:0] map;
      int k;
      map = '0;
      k = 0;
      for (int p = 1; p <= 3; p++) if (!off[p]) begin
         k++;
         map[k] = 2'(p);
      end
      repeat (2) @(posedge mclk);
      #1;
      chk({5'h00, port_enabled}, {5'h00, ~off});
      chk({6'h00, reported_port_count}, 8'(k));
      chk({2'h0, host_to_phys}, {2'h0, map});
   endtask
   // ==========================================================
   // Scenarios
   task automatic t_reset();
      host.rd(BUS_OFF_MASK_ADDR, v);
      chk(v, 8'h00);
      host.rd(SELF_POWER_ADDR, v);
      chk(v, 8'h01);
      host.rd(8'h20, v);
      chk(v, 8'h00);
      // A write to a neighbouring address touches neither register
      host.wr(8'h0D, 8'hFF);
      host.rd(BUS_OFF_MASK_ADDR, v);
      chk(v, 8'h00);
      host.rd(SELF_POWER_ADDR, v);
      chk(v, 8'h01);
   endtask
   // Reserved bits written high must read back low
   task automatic t_masks();
      for (int m = 7; m >= 0; m--) begin
         host.wr(BUS_OFF_MASK_ADDR, {4'hF, 3'(m), 1'b1});
         host.rd(BUS_OFF_MASK_ADDR, v);
         chk(v, {4'h0, 3'(m), 1'b0});
         chk_view(3'(m));
      end
   endtask
   task automatic t_remap();
      port_remap_enable = 1'b1;
      remap_off_mask = 3'b101;
      chk_view(3'b101);
      port_remap_enable = 1'b0;
   endtask
   // Self powered ignores the bus powered mask; back on bus power it bites
   task automatic t_power();
      host.wr(SELF_POWER_ADDR, 8'h32);
      host.wr(BUS_OFF_MASK_ADDR, 8'h0E);
      bus_powered = 1'b0;
      chk_view(3'b000);
      chk(desc_max_power, 8'h32);
      chk({7'h00, desc_max_power_valid}, 8'h01);
      host.rd(SELF_POWER_ADDR, v);
      chk(v, 8'h32);
      bus_powered = 1'b1;
      chk_view(3'b111);
      chk(desc_max_power, 8'h00);
      chk({7'h00, desc_max_power_valid}, 8'h00);
   endtask
   // A mid-run reset must restore both registers and the full port view
   task automatic t_rereset();
      reset = 1'b1;
      repeat (2) @(posedge mclk);
      #1;
      reset = 1'b0;
      host.rd(BUS_OFF_MASK_ADDR, v);
      chk(v, 8'h00);
      host.rd(SELF_POWER_ADDR, v);
      chk(v, 8'h01);
      chk_view(3'b000);
   endtask
   // ==========================================================
   // Clock, reset, sequence and watchdog
   initial begin
      mclk = 1'b0;
      forever #5 mclk = ~mclk;
   end
   initial begin
      reset = 1'b1;
      bus_powered = 1'b1;
      port_remap_enable = 1'b0;
      remap_off_mask = 3'b000;
      repeat (16) @(posedge mclk);
      #1;
      reset = 1'b0;
      t_reset();
      t_masks();
      t_remap();
      t_power();
      t_rereset();
      test_done();
   end
   initial begin
      #100000;
      n_fail++;
      test_done();
   end
endmodule // testbench
